// >>> rtl/adc_highpass_and_sidetone_mixer.sv
// Purpose: ADC high-pass filter and digital sidetone mixer into the DACs
// Assumes: One shared sample strobe when ADC and DAC rates match
// Notes:   Registers reached by index over a simple read/write port
`include "sidetone_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_highpass_and_sidetone_mixer (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic [7:0]            reg_index,
    input  wire logic                  reg_write,
    input  wire logic [15:0]           reg_wdata,
    output logic [15:0]                reg_rdata,
    input  wire logic                  rates_match,
    input  wire logic                  adc_strobe,
    input  wire sidetone_pkg::stereo_t adc_in,
    output logic                       adc_out_strobe,
    output sidetone_pkg::stereo_t      adc_out,
    input  wire logic                  dac_strobe,
    input  wire sidetone_pkg::stereo_t dac_in,
    output logic                       dac_out_strobe,
    output sidetone_pkg::stereo_t      dac_out
);

    typedef struct packed {
        sidetone_pkg::config_t cfg;
        logic [15:0]           rdata;
        logic                  adc_stb;
        sidetone_pkg::stereo_t adc;
        sidetone_pkg::stereo_t tone;
        logic                  dac_stb;
        sidetone_pkg::stereo_t dac;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic                  hpf_l_stb;
    logic                  hpf_r_stb;
    sidetone_pkg::stereo_t hpf_out;
    sidetone_pkg::stereo_t mix_src;
    sidetone_pkg::stereo_t mix_scaled;

    hpf_channel #(.ACC_W(32)) u_hpf_left (
        .clk           (clk),
        .rstn          (rstn),
        .sample_strobe (adc_strobe),
        .enable        (state_r.cfg.hpf_enable),
        .cutoff        (state_r.cfg.hpf_cutoff_select),
        .din           (adc_in.left),
        .out_strobe    (hpf_l_stb),
        .dout          (hpf_out.left)
    );

    hpf_channel #(.ACC_W(32)) u_hpf_right (
        .clk           (clk),
        .rstn          (rstn),
        .sample_strobe (adc_strobe),
        .enable        (state_r.cfg.hpf_enable),
        .cutoff        (state_r.cfg.hpf_cutoff_select),
        .din           (adc_in.right),
        .out_strobe    (hpf_r_stb),
        .dout          (hpf_out.right)
    );

    function automatic sidetone_pkg::sample_t pick(
        input sidetone_pkg::source_t sel,
        input sidetone_pkg::stereo_t s
    );
        case (sel)
            sidetone_pkg::SRC_LEFT_ADC:  pick = s.left;
            sidetone_pkg::SRC_RIGHT_ADC: pick = s.right;
            default:                     pick = '0;
        endcase
    endfunction : pick

    function automatic sidetone_pkg::sample_t sat_add(
        input sidetone_pkg::sample_t a,
        input sidetone_pkg::sample_t b
    );
        logic signed [16:0] s;
        s = 17'(a) + 17'(b);
        if (s[16] != s[15])
            sat_add = s[16] ? 16'sh8000 : 16'sh7fff;
        else
            sat_add = s[15:0];
    endfunction : sat_add

    // Sidetone source per DAC channel, from filtered samples
    always_comb begin
        mix_src.left  = pick(state_r.cfg.left_sidetone_source,
                             state_r.adc);
        mix_src.right = pick(state_r.cfg.right_sidetone_source,
                             state_r.adc);
    end

    sidetone_gain u_gain_left (
        .code (state_r.cfg.left_sidetone_gain),
        .din  (mix_src.left),
        .dout (mix_scaled.left)
    );

    sidetone_gain u_gain_right (
        .code (state_r.cfg.right_sidetone_gain),
        .din  (mix_src.right),
        .dout (mix_scaled.right)
    );

    always_comb begin
        state_nxt = state_r;
        if (reg_write) begin
            case (reg_index)
                `OFS_BLOCK_POWER_ENABLES: begin
                    state_nxt.cfg.power_other = reg_wdata;
                    state_nxt.cfg.hpf_enable =
                        reg_wdata[`POS_HPF_ENABLE_POWER];
                end
                `OFS_ADC_PATH_CONTROL: begin
                    state_nxt.cfg.adc_other = reg_wdata;
                    state_nxt.cfg.hpf_enable =
                        reg_wdata[`POS_HPF_ENABLE_ADC];
                    state_nxt.cfg.hpf_cutoff_select =
                        reg_wdata[`POS_HPF_CUTOFF_LO +: 2];
                end
                `OFS_SIDETONE_ROUTING: begin
                    state_nxt.cfg.routing_other = reg_wdata;
                    state_nxt.cfg.left_sidetone_source =
                        sidetone_pkg::source_t'(
                            reg_wdata[`POS_LEFT_SOURCE_LO +: 2]);
                    state_nxt.cfg.right_sidetone_source =
                        sidetone_pkg::source_t'(
                            reg_wdata[`POS_RIGHT_SOURCE_LO +: 2]);
                end
                `OFS_SIDETONE_GAIN_AND_DIVIDER: begin
                    state_nxt.cfg.gain_other = reg_wdata;
                    state_nxt.cfg.left_sidetone_gain =
                        reg_wdata[`POS_LEFT_GAIN_LO +: 4];
                    state_nxt.cfg.right_sidetone_gain =
                        reg_wdata[`POS_RIGHT_GAIN_LO +: 4];
                end
                default: ;
            endcase
        end

        // Read path shows live fields merged into stored words
        case (reg_index)
            `OFS_BLOCK_POWER_ENABLES: begin
                state_nxt.rdata = state_r.cfg.power_other;
                state_nxt.rdata[`POS_HPF_ENABLE_POWER] =
                    state_r.cfg.hpf_enable;
            end
            `OFS_ADC_PATH_CONTROL: begin
                state_nxt.rdata = state_r.cfg.adc_other;
                state_nxt.rdata[`POS_HPF_ENABLE_ADC] =
                    state_r.cfg.hpf_enable;
                state_nxt.rdata[`POS_HPF_CUTOFF_LO +: 2] =
                    state_r.cfg.hpf_cutoff_select;
            end
            `OFS_SIDETONE_ROUTING: begin
                state_nxt.rdata = state_r.cfg.routing_other;
                state_nxt.rdata[`POS_LEFT_SOURCE_LO +: 2] =
                    state_r.cfg.left_sidetone_source;
                state_nxt.rdata[`POS_RIGHT_SOURCE_LO +: 2] =
                    state_r.cfg.right_sidetone_source;
            end
            `OFS_SIDETONE_GAIN_AND_DIVIDER: begin
                state_nxt.rdata = state_r.cfg.gain_other;
                state_nxt.rdata[`POS_LEFT_GAIN_LO +: 4] =
                    state_r.cfg.left_sidetone_gain;
                state_nxt.rdata[`POS_RIGHT_GAIN_LO +: 4] =
                    state_r.cfg.right_sidetone_gain;
            end
            default: state_nxt.rdata = '0;
        endcase

        // Filtered ADC samples, also held as sidetone source
        state_nxt.adc_stb = hpf_l_stb & hpf_r_stb;
        if (hpf_l_stb & hpf_r_stb)
            state_nxt.adc = hpf_out;

        // Scaled sidetone, zero when rates differ
        if (rates_match) begin
            state_nxt.tone = mix_scaled;
        end else begin
            state_nxt.tone = '0;
        end

        state_nxt.dac_stb = dac_strobe;
        if (dac_strobe) begin
            state_nxt.dac.left  = sat_add(dac_in.left,
                                          state_r.tone.left);
            state_nxt.dac.right = sat_add(dac_in.right,
                                          state_r.tone.right);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= '0;
            state_r.cfg.hpf_enable <= `RST_HPF_ENABLE;
            state_r.cfg.hpf_cutoff_select <= `RST_HPF_CUTOFF;
            state_r.cfg.left_sidetone_gain <= `RST_GAIN;
            state_r.cfg.right_sidetone_gain <= `RST_GAIN;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign reg_rdata      = state_r.rdata;
    assign adc_out_strobe = state_r.adc_stb;
    assign adc_out        = state_r.adc;
    assign dac_out_strobe = state_r.dac_stb;
    assign dac_out        = state_r.dac;

endmodule : adc_highpass_and_sidetone_mixer

`default_nettype wire

// >>> rtl/hpf_channel.sv
// Purpose: One channel of the DC-removing high-pass filter
// Assumes: One sample per strobe; coefficient is a power of two
// Notes:   Two cascaded one-pole sections; second bypassed in first order
`include "sidetone_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module hpf_channel #(
    parameter int ACC_W = 32
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 sample_strobe,
    input  wire logic                 enable,
    input  wire logic [1:0]           cutoff,
    input  wire sidetone_pkg::sample_t din,
    output logic                      out_strobe,
    output sidetone_pkg::sample_t     dout
);

    typedef struct packed {
        logic signed [ACC_W-1:0] dc1;
        logic signed [ACC_W-1:0] dc2;
        logic                    stb;
        sidetone_pkg::sample_t   y;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    localparam int FRAC = `HPF_SHIFT_FIRST;

    function automatic sidetone_pkg::sample_t sat(
        input logic signed [ACC_W-1:0] v
    );
        if (v > 32767)
            sat = 16'sh7fff;
        else if (v < -32768)
            sat = 16'sh8000;
        else
            sat = v[15:0];
    endfunction : sat

    logic [3:0]              shift;
    logic                    second;
    logic signed [ACC_W-1:0] x_ext;
    logic signed [ACC_W-1:0] e1;
    logic signed [ACC_W-1:0] e2;

    always_comb begin
        case (cutoff)
            2'h0:    shift = 4'(`HPF_SHIFT_FIRST);
            2'h1:    shift = 4'(`HPF_SHIFT_CUT1);
            2'h2:    shift = 4'(`HPF_SHIFT_CUT2);
            default: shift = 4'(`HPF_SHIFT_CUT3);
        endcase
        second = (cutoff != 2'h0);
        x_ext = ACC_W'(din) <<< FRAC;
        e1 = x_ext - state_r.dc1;
        e2 = e1 - state_r.dc2;
        state_nxt = state_r;
        state_nxt.stb = sample_strobe;
        if (sample_strobe) begin
            if (enable) begin
                state_nxt.dc1 = state_r.dc1 + (e1 >>> shift);
                if (second) begin
                    state_nxt.dc2 = state_r.dc2 + (e2 >>> shift);
                    state_nxt.y = sat(e2 >>> FRAC);
                end else begin
                    state_nxt.dc2 = '0;
                    state_nxt.y = sat(e1 >>> FRAC);
                end
            end else begin
                state_nxt.dc1 = '0;
                state_nxt.dc2 = '0;
                state_nxt.y = din;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign out_strobe = state_r.stb;
    assign dout = state_r.y;

endmodule : hpf_channel

`default_nettype wire

// >>> rtl/sidetone_defines.svh
// Purpose: Offsets, field positions, reset values for the ADC filter and mixer
// Assumes: 16-bit register words, 8-bit register index
// Notes:   Definitions only
`ifndef SIDETONE_DEFINES_SVH
`define SIDETONE_DEFINES_SVH

`define OFS_BLOCK_POWER_ENABLES       8'h0b
`define OFS_SIDETONE_ROUTING          8'h3c
`define OFS_ADC_PATH_CONTROL          8'h40
`define OFS_SIDETONE_GAIN_AND_DIVIDER 8'h44

`define POS_HPF_ENABLE_POWER          13
`define POS_HPF_ENABLE_ADC            15
`define POS_HPF_CUTOFF_LO             8
`define POS_LEFT_SOURCE_LO            12
`define POS_RIGHT_SOURCE_LO           10
`define POS_LEFT_GAIN_LO              8
`define POS_RIGHT_GAIN_LO             4

`define RST_REG_WORD                  16'h0000
`define RST_HPF_ENABLE                1'b0
`define RST_HPF_CUTOFF                2'h0
`define RST_SOURCE                    2'h0
`define RST_GAIN                      4'h0

`define GAIN_CODE_UNITY               4'hc
`define HPF_SHIFT_FIRST               11
`define HPF_SHIFT_CUT1                5
`define HPF_SHIFT_CUT2                4
`define HPF_SHIFT_CUT3                3

`endif

// >>> rtl/sidetone_gain.sv
// Purpose: Scales a sample by the sidetone gain code
// Assumes: Combinational; Q1.15 gain table
// Notes:   Codes 12 and above give unity
`include "sidetone_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sidetone_gain (
    input  wire logic [3:0]            code,
    input  wire sidetone_pkg::sample_t din,
    output sidetone_pkg::sample_t      dout
);

    logic [15:0]        coef;
    logic signed [32:0] prod;

    always_comb begin
        case (code)
            4'h0:    coef = 16'h0207;
            4'h1:    coef = 16'h02de;
            4'h2:    coef = 16'h040c;
            4'h3:    coef = 16'h05b8;
            4'h4:    coef = 16'h0814;
            4'h5:    coef = 16'h0b68;
            4'h6:    coef = 16'h101d;
            4'h7:    coef = 16'h16c3;
            4'h8:    coef = 16'h2027;
            4'h9:    coef = 16'h2d6b;
            4'ha:    coef = 16'h4027;
            4'hb:    coef = 16'h5a9e;
            default: coef = 16'h8000;
        endcase
        prod = 33'(din) * $signed({1'b0, coef});
        if (code >= `GAIN_CODE_UNITY)
            dout = din;
        else
            dout = prod[30:15];
    end

endmodule : sidetone_gain

`default_nettype wire

// >>> rtl/sidetone_pkg.sv
// Purpose: Types shared by the filter and mixer files
// Assumes: 16-bit audio samples
// Notes:   Constants live in the defines header
package sidetone_pkg;

    typedef logic signed [15:0] sample_t;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_LEFT_ADC,
        SRC_RIGHT_ADC,
        SRC_UNUSED
    } source_t;

    typedef struct packed {
        sample_t left;
        sample_t right;
    } stereo_t;

    typedef struct packed {
        logic        hpf_enable;
        logic [1:0]  hpf_cutoff_select;
        source_t     left_sidetone_source;
        source_t     right_sidetone_source;
        logic [3:0]  left_sidetone_gain;
        logic [3:0]  right_sidetone_gain;
        logic [15:0] power_other;
        logic [15:0] routing_other;
        logic [15:0] adc_other;
        logic [15:0] gain_other;
    } config_t;

endpackage : sidetone_pkg

// >>> verification/adc_highpass_and_sidetone_mixer_tb_top.sv
// Purpose: Register, filter and sidetone tests for the mixer
// Assumes: Inputs driven on the falling edge
// Notes:   Gain expectations from the dB table, small tolerance
`timescale 1ns/1ps
`default_nettype none

module adc_highpass_and_sidetone_mixer_tb_top;
    logic                  clk;
    logic                  rstn;
    logic                  reg_write;
    logic                  rates_match;
    logic                  adc_strobe;
    logic                  dac_strobe;
    logic                  adc_out_strobe;
    logic                  dac_out_strobe;
    logic [7:0]            reg_index;
    logic [15:0]           reg_wdata;
    logic [15:0]           reg_rdata;
    logic [15:0]           v;
    logic [15:0]           t;
    logic [7:0]            reset_idx [5] = '{8'h0b, 8'h3c, 8'h40,
                                             8'h44, 8'h41};
    // Second filter output for a 0x1000 step, per cutoff code
    logic [15:0]           hpf_step [4] = '{16'h0ffe, 16'h0f00,
                                            16'h0e00, 16'h0c00};
    sidetone_pkg::stereo_t adc_in;
    sidetone_pkg::stereo_t dac_in;
    sidetone_pkg::stereo_t adc_out;
    sidetone_pkg::stereo_t dac_out;
    int                    fail_count = 0;
    int                    checked = 0;
    int                    n;
    int                    e;

    adc_highpass_and_sidetone_mixer i_adc_highpass_and_sidetone_mixer (
        .clk, .rstn, .reg_index, .reg_write, .reg_wdata, .reg_rdata,
        .rates_match, .adc_strobe, .adc_in, .adc_out_strobe, .adc_out,
        .dac_strobe, .dac_in, .dac_out_strobe, .dac_out
    );

    audio_stream_source i_audio_stream_source (
        .clk, .adc_strobe, .adc_in, .dac_strobe, .dac_in
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic near(input logic [15:0] seen, input int exp, input int tol);
        int d;
        d = $signed(seen) - exp;
        check((d >= -tol && d <= tol) ? 16'h0001 : 16'h0000, 16'h0001);
    endtask : near

    task automatic wr(input logic [7:0] i, input logic [15:0] d);
        @(negedge clk);
        reg_index = i;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] i, output logic [15:0] d);
        @(negedge clk);
        reg_index = i;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd

    task automatic adc(input logic [15:0] l, input logic [15:0] r);
        i_audio_stream_source.send_adc({l, r});
        for (n = 0; n < 8 && adc_out_strobe !== 1'b1; n++)
            @(negedge clk);
        if (n == 8) begin
            fail_count++;
            summarize();
        end
        // Let the gained sidetone settle
        repeat (2) @(negedge clk);
    endtask : adc

    task automatic dac(input logic [15:0] l, input logic [15:0] r);
        i_audio_stream_source.send_dac({l, r});
        for (n = 0; n < 8 && dac_out_strobe !== 1'b1; n++)
            @(negedge clk);
        if (n == 8) begin
            fail_count++;
            summarize();
        end
    endtask : dac

    initial begin
        rstn        = 1'b0;
        reg_index   = 8'h00;
        reg_write   = 1'b0;
        reg_wdata   = 16'h0000;
        rates_match = 1'b1;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        foreach (reset_idx[k]) begin
            rd(reset_idx[k], v);
            check(v, 16'h0000);
        end
        $display("reset values done");
        wr(8'h40, 16'h8100);
        rd(8'h0b, v);
        check(v, 16'h2000);
        wr(8'h0b, 16'h0000);
        rd(8'h40, v);
        check(v, 16'h0100);
        wr(8'h40, 16'h0000);
        $display("enable alias done");
        // ADC samples flow before any DAC traffic
        wr(8'h44, 16'h0cc0);
        for (int s = 0; s < 4; s++) begin
            wr(8'h3c, 16'((s << 12) | (s << 10)));
            adc(16'h0100, 16'h0200);
            check(adc_out.left, 16'h0100);
            check(adc_out.right, 16'h0200);
            dac(16'h1000, 16'h2000);
            t = (s == 1) ? 16'h0100 : (s == 2) ? 16'h0200 : 16'h0000;
            check(dac_out.left, 16'h1000 + t);
            check(dac_out.right, 16'h2000 + t);
        end
        $display("source select done");
        // Silent interface data keeps every sum clear of clipping
        wr(8'h3c, 16'h1800);
        for (int c = 0; c < 16; c++) begin
            wr(8'h44, 16'((c << 8) | (c << 4)));
            adc(16'h4000, 16'h4000);
            dac(16'h0000, 16'h0000);
            e = int'(16384.0 *
                     10.0 ** (-(36 - 3 * ((c > 12) ? 12 : c)) / 20.0));
            near(dac_out.left, e, 3);
            near(dac_out.right, e, 3);
        end
        $display("gain sweep done");
        adc(16'h7000, 16'h9000);
        dac(16'h7000, 16'h9000);
        check(dac_out.left, 16'h7fff);
        check(dac_out.right, 16'h8000);
        rates_match = 1'b0;
        dac(16'h1000, 16'h1000);
        check(dac_out.left, 16'h1000);
        rates_match = 1'b1;
        $display("saturation and rate mismatch done");
        wr(8'h40, 16'h8300);
        repeat (100) adc(16'h1000, 16'h1000);
        near(adc_out.left, 0, 63);
        dac(16'h0100, 16'h0100);
        near(dac_out.left, 256, 63);
        // Second output after a cleared start tells the cutoffs apart
        foreach (hpf_step[k]) begin
            wr(8'h40, 16'h0000);
            adc(16'h1000, 16'h1000);
            wr(8'h40, 16'(32'h8000 | (k << 8)));
            repeat (2) adc(16'h1000, 16'h1000);
            check(adc_out.left, hpf_step[k]);
            check(adc_out.right, hpf_step[k]);
        end
        // Filter state only clears on a bypassed sample
        wr(8'h40, 16'h0000);
        adc(16'h1000, 16'h1000);
        wr(8'h40, 16'h8000);
        repeat (40) adc(16'h1000, 16'h1000);
        near(adc_out.left, 4016, 16);
        $display("filter done");
        summarize();
    end
endmodule : adc_highpass_and_sidetone_mixer_tb_top

`default_nettype wire

// >>> verification/audio_stream_source.sv
// Purpose: Decimator output and interface sample source
// Assumes: ADC and DAC at one shared rate
// Notes:   Data goes stale (inverted) between strobes
`timescale 1ns/1ps
`default_nettype none

module audio_stream_source (
    input  wire logic             clk,
    output logic                  adc_strobe,
    output sidetone_pkg::stereo_t adc_in,
    output logic                  dac_strobe,
    output sidetone_pkg::stereo_t dac_in
);
    initial begin
        adc_strobe = 1'b0;
        dac_strobe = 1'b0;
        adc_in     = '0;
        dac_in     = '0;
    end

    // One sample per strobe on the common rate clock
    task automatic send_adc(input sidetone_pkg::stereo_t s);
        @(negedge clk);
        adc_strobe = 1'b1;
        adc_in     = s;
        @(negedge clk);
        adc_strobe = 1'b0;
        adc_in     = ~s;
    endtask : send_adc

    task automatic send_dac(input sidetone_pkg::stereo_t s);
        @(negedge clk);
        dac_strobe = 1'b1;
        dac_in     = s;
        @(negedge clk);
        dac_strobe = 1'b0;
        dac_in     = ~s;
    endtask : send_dac
endmodule : audio_stream_source

`default_nettype wire

// >>> verification/mixer_checker_properties.sv
// Purpose: Port-level checks on the filter and sidetone mixer
// Assumes: Filter enable shadowed from register writes
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none

module mixer_checker (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic [7:0]            reg_index,
    input wire logic                  reg_write,
    input wire logic [15:0]           reg_wdata,
    input wire logic [15:0]           reg_rdata,
    input wire logic                  adc_strobe,
    input wire sidetone_pkg::stereo_t adc_in,
    input wire logic                  adc_out_strobe,
    input wire sidetone_pkg::stereo_t adc_out,
    input wire logic                  dac_strobe,
    input wire logic                  dac_out_strobe,
    input wire sidetone_pkg::stereo_t dac_out
);
    logic hpf_en_r;
    logic mapped;

    assign mapped = reg_index inside {8'h0b, 8'h3c, 8'h40, 8'h44};

    // Shadow of the shared filter enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            hpf_en_r <= 1'b0;
        else if (reg_write && reg_index == 8'h0b)
            hpf_en_r <= reg_wdata[13];
        else if (reg_write && reg_index == 8'h40)
            hpf_en_r <= reg_wdata[15];
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    adc_latency_a : assert property (
        adc_strobe |-> ##2 adc_out_strobe) else $error("adc answer late");
    adc_origin_a : assert property (
        adc_out_strobe |-> $past(adc_strobe, 2)) else $error("stray adc out");
    adc_hold_a : assert property (
        !adc_out_strobe |-> $stable(adc_out)) else $error("adc out moved");
    hpf_bypass_a : assert property (
        (adc_strobe && !hpf_en_r) ##1 !hpf_en_r |=>
        adc_out == $past(adc_in, 2)) else $error("bypass altered data");
    dac_latency_a : assert property (
        dac_strobe |=> dac_out_strobe) else $error("dac answer late");
    dac_hold_a : assert property (
        !dac_out_strobe |-> $stable(dac_out)) else $error("dac out moved");
    enable_alias_a : assert property (
        (reg_index == 8'h0b && !reg_write) ##1
        (reg_index == 8'h40 && !reg_write) |=>
        reg_rdata[15] == $past(reg_rdata[13])) else $error("enable split");
    routing_store_a : assert property (
        (reg_write && reg_index == 8'h3c) ##1
        (reg_index == 8'h3c && !reg_write) |=>
        reg_rdata == $past(reg_wdata, 2)) else $error("routing not kept");
    unmapped_read_a : assert property (
        !mapped |=> reg_rdata == 16'h0000) else $error("unmapped not zero");

    cover property (adc_out_strobe && hpf_en_r);
    cover property (dac_out_strobe && dac_out.left == 16'sh7fff);
    cover property (reg_write && reg_index == 8'h40);
endmodule : mixer_checker

bind adc_highpass_and_sidetone_mixer mixer_checker i_mixer_checker (
    .clk, .rstn, .reg_index, .reg_write, .reg_wdata, .reg_rdata,
    .adc_strobe, .adc_in, .adc_out_strobe, .adc_out,
    .dac_strobe, .dac_out_strobe, .dac_out
);

`default_nettype wire
